// ### common/qarc_pkg.sv
// Purpose: Shared constants and carrier types of the quad converter readout control.
// Assumes: The control clock runs at 40 MHz; all cycle counts below derive from that period.
// Notes:   Times are kept in ns and converted to cycles here, rounding a least time up.

package qarc_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS    = 25;
  // Conversion time measured on the internal oscillator, not on the serial clock.
  localparam int CONV_TIME_NS     = 300;
  localparam int CONV_CYCLES      = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELFTEST_TIME_NS = 2000;
  localparam int SELFTEST_CYCLES  = (SELFTEST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Frame layout
  // ==========================================================================
  localparam int CHANNELS             = 4;
  localparam int RESULT_BITS_NORMAL   = 16;
  localparam int RESULT_BITS_BOOST    = 18;
  localparam int CRC_BITS             = 8;
  localparam int REG_FRAME_MIN_CLOCKS = 16;
  localparam int LANE_VEC_BITS        = 80;

  // ==========================================================================
  // Configuration
  // ==========================================================================
  localparam logic POWER_NORMAL   = 1'b0;
  localparam logic POWER_SHUTDOWN = 1'b1;

  typedef enum logic [1:0] {
    LANES_TWO     = 2'b00,
    LANES_ONE     = 2'b01,
    LANES_FOUR    = 2'b10,
    LANES_ONE_ALT = 2'b11
  } qarc_lane_mode_type;

  typedef struct packed {
    logic               power_down_select;
    qarc_lane_mode_type output_lane_select;
    logic               resolution_boost_enable;
    logic               crc_read_enable;
  } qarc_cfg_type;

  localparam qarc_cfg_type CFG_DEFAULT = '{POWER_NORMAL, LANES_TWO, 1'b0, 1'b0};

  // ==========================================================================
  // Data carriers and states
  // ==========================================================================
  typedef logic [RESULT_BITS_BOOST-1:0]                 qarc_word_type;
  typedef qarc_word_type [CHANNELS-1:0]                 qarc_words_type;
  typedef logic [CHANNELS-1:0][LANE_VEC_BITS-1:0]       qarc_lanes_type;

  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_BUSY = 2'b01,
    CV_TEST = 2'b10
  } qarc_conv_state_type;

endpackage

// ### rtl/qarc_sync.sv
// Purpose: Two flip-flop synchroniser for one pin sampled by the control clock.
// Assumes: The input is asynchronous to clk_i.
// Notes:   Only the second stage leaves the module.

`timescale 1ns/10ps

module qarc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Pin side
  input  wire logic async_i,
  // Clock domain side
  output logic      sync_o
);

  typedef struct packed {
    logic meta;
    logic sync;
  } qarc_sync_state_type;

  qarc_sync_state_type st;
  qarc_sync_state_type next_st;

  always_comb begin
    next_st.meta = async_i;
    next_st.sync = st.meta;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st <= '{RST_VAL, RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.sync;

endmodule // qarc_sync

// ### rtl/qarc_readout.sv
// Purpose: Control and serial readout of a four channel simultaneous sampling converter.
// Assumes: Serial pins are asynchronous and pass two flip-flops; config and reset requests
//          come from a register decoder on clk_i.
// Notes:   Overview of operation follows.
//
// Overview of operation
// - One config bit picks power mode: 0 normal, 1 shutdown; written to enter or leave.
// - Shutdown powers the converter down while the serial port keeps working.
// - Power mode changes never alter any other configuration value.
// - Soft and hard reset are both requested through the serial register write path.
// - Soft reset keeps config, restarts interface and conversion but not a running self test, flushes, clears alert status.
// - Hard reset adds config defaults and a reference and oscillator restart.
// - Power-on and hard reset run a self test; failure sets the setup fail flag.
// - Chip select fall holds and captures inputs and drives the result lanes.
// - Conversion is timed by the internal clock, independent of the serial clock.
// - Register frames carry at least 16 serial clocks while chip select is low.
// - A chip select fall with the converter idle in normal power mode starts all four channel conversions together.
// - A frame returns the previous conversion and starts the next one.
// - Results go MSB first; first bit at select fall, next bits on clock rises.
// - Chip select rise returns every result lane to high impedance.
// - Result frame clocks: 16/18 four lanes, 32/36 two lanes, 64/72 one lane.
// - Read check adds eight clocks: 24/26, 40/44, 72/80.
// - Lane select 0b10 gives four lanes, 0b00 gives two lanes.
// - Two-lane mode sends A and C on lane A, B and D on lane B.
// - One-lane mode sends A, B, C, D in turn on lane A.

`timescale 1ns/10ps

module qarc_readout
  import qarc_pkg::*;
(
  // Clock and reset
  input  wire logic           clk_i,
  input  wire logic           srst_i,
  // Serial link pins
  input  wire logic           cs_n_i,
  input  wire logic           sclk_i,
  input  wire logic           serial_command_in_i,
  output logic                result_lane_a_o,
  output logic                result_lane_a_oe_o,
  output logic                result_lane_b_o,
  output logic                result_lane_b_oe_o,
  output logic                result_lane_c_o,
  output logic                result_lane_c_oe_o,
  output logic                result_lane_d_o,
  output logic                result_lane_d_oe_o,
  // Configuration and reset requests from the register decoder
  input  wire logic           cfg_wr_i,
  input  wire qarc_cfg_type   cfg_i,
  input  wire logic           soft_reset_i,
  input  wire logic           hard_reset_i,
  output qarc_cfg_type        cfg_o,
  // Converter core
  input  wire qarc_words_type conv_data_i,
  input  wire logic [7:0]     crc_value_i,
  input  wire logic           selftest_fault_i,
  output logic                analog_power_down_o,
  output logic                sample_strobe_o,
  output logic                sample_hold_o,
  output logic                conv_done_o,
  output logic                analog_reinit_o,
  output logic                pipe_flush_o,
  output logic                alert_clear_o,
  // Status
  output logic                setup_fail_o,
  output logic [6:0]          frame_bits_o,
  output logic                frame_short_o,
  output logic [15:0]         cmd_word_o,
  output logic                cmd_valid_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    qarc_cfg_type        cfg;
    qarc_conv_state_type conv;
    logic [7:0]          cnt;
    qarc_words_type      result;
    qarc_lanes_type      lanes;
    logic                frame_active;
    logic                cs_prev;
    logic                sclk_prev;
    logic [6:0]          sclk_count;
    logic [6:0]          frame_bits;
    logic [15:0]         cmd_shift;
    logic [15:0]         cmd_word;
    logic                cmd_valid;
    logic                frame_short;
    logic                setup_fail;
    logic                sample_strobe;
    logic                conv_done;
    logic                reinit;
    logic                flush;
    logic                alert_clear;
  } qarc_state_type;

  localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);
  localparam logic [7:0] TEST_LAST = 8'(SELFTEST_CYCLES - 1);
  localparam logic [6:0] REG_MIN   = 7'(REG_FRAME_MIN_CLOCKS);
  localparam int         CONV_DLY  = CONV_CYCLES;

  qarc_state_type st;
  qarc_state_type next_st;
  logic           cs_s;
  logic           sclk_s;
  logic           sdi_s;
  logic           cs_fall;
  logic           cs_rise;
  logic           sclk_rise;
  logic           sclk_fall;
  logic           fail_set;
  logic           fail_val;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  qarc_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .async_i (cs_n_i),
    .sync_o  (cs_s)
  );

  qarc_sync #(.RST_VAL(1'b0)) u_sync_sclk (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .async_i (sclk_i),
    .sync_o  (sclk_s)
  );

  qarc_sync #(.RST_VAL(1'b0)) u_sync_sdi (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .async_i (serial_command_in_i),
    .sync_o  (sdi_s)
  );

  assign cs_fall   = st.cs_prev & ~cs_s;
  assign cs_rise   = ~st.cs_prev & cs_s;
  assign sclk_rise = ~st.sclk_prev & sclk_s;
  assign sclk_fall = st.sclk_prev & ~sclk_s;

  // ==========================================================================
  // Lane layout
  // ==========================================================================
  function automatic int unsigned lane_count(input qarc_lane_mode_type m);
    if (m == LANES_FOUR) begin
      return 4;
    end else if (m == LANES_TWO) begin
      return 2;
    end
    return 1;
  endfunction

  function automatic logic [6:0] frame_len(input qarc_cfg_type c);
    int unsigned w;
    int unsigned n;
    w = c.resolution_boost_enable ? RESULT_BITS_BOOST : RESULT_BITS_NORMAL;
    n = (CHANNELS / lane_count(c.output_lane_select)) * w;
    if (c.crc_read_enable) begin
      n = n + CRC_BITS;
    end
    return 7'(n);
  endfunction

  // Channel ch goes to lane ch mod lanes, slot ch div lanes, each slot MSB first.
  function automatic qarc_lanes_type build_lanes(input qarc_words_type res,
                                                 input qarc_cfg_type   c,
                                                 input logic [7:0]     crc);
    qarc_lanes_type l;
    int unsigned    w;
    int unsigned    nl;
    int unsigned    lane;
    int unsigned    slot;
    qarc_word_type  word;
    l  = '0;
    w  = c.resolution_boost_enable ? RESULT_BITS_BOOST : RESULT_BITS_NORMAL;
    nl = lane_count(c.output_lane_select);
    for (int ch = 0; ch < CHANNELS; ch++) begin
      word    = c.resolution_boost_enable ? res[ch] : {res[ch][17:2], 2'b00};
      lane    = ch % nl;
      slot    = ch / nl;
      l[lane] = l[lane] | ({word, 62'h0} >> (slot * w));
    end
    if (c.crc_read_enable) begin
      l[0] = l[0] | ({crc, 72'h0} >> ((CHANNELS / nl) * w));
    end
    return l;
  endfunction

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_st               = st;
    fail_set              = 1'b0;
    fail_val              = 1'b0;
    next_st.cs_prev       = cs_s;
    next_st.sclk_prev     = sclk_s;
    next_st.sample_strobe = 1'b0;
    next_st.conv_done     = 1'b0;
    next_st.reinit        = 1'b0;
    next_st.flush         = 1'b0;
    next_st.alert_clear   = 1'b0;
    next_st.cmd_valid     = 1'b0;
    next_st.frame_short   = 1'b0;

    if (cfg_wr_i) begin
      next_st.cfg = cfg_i;
    end

    unique case (st.conv)
      CV_IDLE: begin
        // A chip select fall in shutdown still runs the readout but converts nothing.
        if (cs_fall && st.cfg.power_down_select == POWER_NORMAL) begin
          next_st.conv          = CV_BUSY;
          next_st.cnt           = 8'h00;
          next_st.sample_strobe = 1'b1;
        end
      end
      CV_BUSY: begin
        if (st.cfg.power_down_select == POWER_SHUTDOWN) begin
          next_st.conv = CV_IDLE;
        end else if (st.cnt == CONV_LAST) begin
          next_st.conv      = CV_IDLE;
          next_st.result    = conv_data_i;
          next_st.conv_done = 1'b1;
        end else begin
          next_st.cnt = st.cnt + 8'h01;
        end
      end
      CV_TEST: begin
        if (st.cnt == TEST_LAST) begin
          next_st.conv = CV_IDLE;
          fail_set     = 1'b1;
          fail_val     = selftest_fault_i | (st.cfg != CFG_DEFAULT);
        end else begin
          next_st.cnt = st.cnt + 8'h01;
        end
      end
      default: begin
        next_st.conv = CV_IDLE;
      end
    endcase

    if (cs_fall) begin
      next_st.frame_active = 1'b1;
      next_st.lanes        = build_lanes(st.result, st.cfg, crc_value_i);
      next_st.frame_bits   = frame_len(st.cfg);
      next_st.sclk_count   = 7'h00;
      next_st.cmd_shift    = 16'h0000;
    end else if (cs_rise && st.frame_active) begin
      next_st.frame_active = 1'b0;
      next_st.cmd_valid    = (st.sclk_count >= REG_MIN);
      next_st.cmd_word     = st.cmd_shift;
      next_st.frame_short  = (st.sclk_count < st.frame_bits) || (st.sclk_count < REG_MIN);
    end else if (st.frame_active) begin
      if (sclk_rise) begin
        for (int i = 0; i < CHANNELS; i++) begin
          next_st.lanes[i] = {st.lanes[i][LANE_VEC_BITS-2:0], 1'b0};
        end
      end
      if (sclk_fall) begin
        if (st.sclk_count < REG_MIN) begin
          next_st.cmd_shift = {st.cmd_shift[14:0], sdi_s};
        end
        if (st.sclk_count != 7'h7f) begin
          next_st.sclk_count = st.sclk_count + 7'h01;
        end
      end
    end

    // A self test in progress survives a soft reset so its verdict is not lost.
    if (soft_reset_i || hard_reset_i) begin
      next_st.frame_active  = 1'b0;
      next_st.sample_strobe = 1'b0;
      next_st.flush         = 1'b1;
      next_st.alert_clear  = 1'b1;
      if (st.conv != CV_TEST) begin
        next_st.conv = CV_IDLE;
      end
    end
    if (hard_reset_i) begin
      next_st.cfg    = CFG_DEFAULT;
      next_st.reinit = 1'b1;
      next_st.conv   = CV_TEST;
      next_st.cnt    = 8'h00;
    end

    // Setup fail lives in the alert status, so a reset clears it unless a verdict lands now.
    if (fail_set) begin
      next_st.setup_fail = fail_val;
    end else if (soft_reset_i || hard_reset_i) begin
      next_st.setup_fail = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st         <= '0;
      st.cfg     <= CFG_DEFAULT;
      st.conv    <= CV_TEST;
      st.cs_prev <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign result_lane_a_o     = st.lanes[0][LANE_VEC_BITS-1];
  assign result_lane_b_o     = st.lanes[1][LANE_VEC_BITS-1];
  assign result_lane_c_o     = st.lanes[2][LANE_VEC_BITS-1];
  assign result_lane_d_o     = st.lanes[3][LANE_VEC_BITS-1];
  assign result_lane_a_oe_o  = st.frame_active;
  assign result_lane_b_oe_o  = st.frame_active;
  assign result_lane_c_oe_o  = st.frame_active;
  assign result_lane_d_oe_o  = st.frame_active;
  assign cfg_o               = st.cfg;
  assign analog_power_down_o = st.cfg.power_down_select;
  assign sample_strobe_o     = st.sample_strobe;
  assign sample_hold_o       = (st.conv == CV_BUSY);
  assign conv_done_o         = st.conv_done;
  assign analog_reinit_o     = st.reinit;
  assign pipe_flush_o        = st.flush;
  assign alert_clear_o       = st.alert_clear;
  assign setup_fail_o        = st.setup_fail;
  assign frame_bits_o        = st.frame_bits;
  assign frame_short_o       = st.frame_short;
  assign cmd_word_o          = st.cmd_word;
  assign cmd_valid_o         = st.cmd_valid;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_frame_open;
    cs_fall && !soft_reset_i && !hard_reset_i;
  endsequence

  sequence s_lanes_driven;
    result_lane_a_oe_o && result_lane_b_oe_o && result_lane_c_oe_o && result_lane_d_oe_o;
  endsequence

  sequence s_lanes_released;
    !result_lane_a_oe_o && !result_lane_b_oe_o && !result_lane_c_oe_o && !result_lane_d_oe_o;
  endsequence

  chk_shutdown_no_conv: assert property (
    cs_fall && st.conv == CV_IDLE && st.cfg.power_down_select && !hard_reset_i
    |=> st.conv == CV_IDLE && !sample_strobe_o)
    else $error("conversion started in shutdown");

  chk_port_in_shutdown: assert property (
    (s_frame_open ##0 analog_power_down_o) |=> s_lanes_driven)
    else $error("serial port dead in shutdown");

  chk_cfg_hold: assert property (
    !cfg_wr_i && !hard_reset_i |=> $stable(cfg_o))
    else $error("configuration changed without a write");

  chk_soft_reset_keep: assert property (
    soft_reset_i && !hard_reset_i && !cfg_wr_i
    |=> $stable(cfg_o) && pipe_flush_o && alert_clear_o ##0 s_lanes_released)
    else $error("soft reset effect wrong");

  chk_hard_reset_load: assert property (
    hard_reset_i |=> cfg_o == CFG_DEFAULT && analog_reinit_o && st.conv == CV_TEST && st.cnt == 8'h00)
    else $error("hard reset effect wrong");

  chk_selftest_verdict: assert property (
    st.conv == CV_TEST && st.cnt == TEST_LAST && !hard_reset_i && st.cfg == CFG_DEFAULT
    |=> setup_fail_o == $past(selftest_fault_i) && st.conv == CV_IDLE)
    else $error("self test verdict wrong");

  chk_conv_time: assert property (
    conv_done_o |-> $past(sample_strobe_o, CONV_DLY))
    else $error("conversion time wrong");

  chk_hold_together: assert property (
    sample_strobe_o |-> sample_hold_o ##1 (sample_hold_o || conv_done_o || pipe_flush_o || analog_power_down_o))
    else $error("hold not taken with the sample");

  chk_cmd_min_clocks: assert property (
    cmd_valid_o |-> $past(st.sclk_count) >= REG_MIN && $past(cs_rise))
    else $error("command accepted from a short frame");

  chk_first_bit_four: assert property (
    (s_frame_open ##0 st.cfg.output_lane_select == LANES_FOUR)
    |=> s_lanes_driven ##0 result_lane_c_o == $past(st.result[2][17]))
    else $error("first bit on lane c wrong");

  chk_first_bit_two: assert property (
    (s_frame_open ##0 st.cfg.output_lane_select == LANES_TWO) |=> result_lane_b_o == $past(st.result[1][17]))
    else $error("first bit on lane b wrong");

  chk_shift_on_rise: assert property (
    st.frame_active && sclk_rise && !cs_rise && !soft_reset_i && !hard_reset_i
    |=> result_lane_a_o == $past(st.lanes[0][LANE_VEC_BITS-2]))
    else $error("lane a did not shift on the clock rise");

  chk_release_on_rise: assert property (
    cs_rise && st.frame_active |=> s_lanes_released)
    else $error("lanes still driven after chip select rise");

  chk_len_four_plain: assert property (
    (s_frame_open ##0 st.cfg.output_lane_select == LANES_FOUR && !st.cfg.resolution_boost_enable
     && !st.cfg.crc_read_enable) |=> frame_bits_o == 7'd16)
    else $error("four lane frame length wrong");

  chk_len_one_full: assert property (
    (s_frame_open ##0 st.cfg.output_lane_select == LANES_ONE && st.cfg.resolution_boost_enable
     && st.cfg.crc_read_enable) |=> frame_bits_o == 7'd80)
    else $error("one lane frame length wrong");

endmodule // qarc_readout

// ### tb/qarc_host.sv
// Purpose: Host serial master model for the readout control.
// Assumes: Pins move on clk_i edges; each sclk phase is 4 clk (100 ns).
// Notes:   Lanes are taken at each sclk rise, before that rise's shift lands.
`timescale 1ns/10ps
module qarc_host
  import qarc_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Link
  output logic            cs_n_o,
  output logic            sclk_o,
  output logic            sdi_o,
  input  wire logic [15:0] cmd_i,
  input  wire logic [3:0] lane_i,
  input  wire logic       oe_i,
  input  wire logic [6:0] bits_i,
  // Capture
  output qarc_lanes_type  cap_o,
  output logic [6:0]      bits_o,
  output logic [1:0]      oe_o,
  output logic            done_o
);
  initial begin
    {cs_n_o, sclk_o, sdi_o, done_o} = 4'h8;
  end
  // ==========================================================================
  // Frame
  // ==========================================================================
  task automatic frame(input int n);
    cap_o = '0;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    bits_o = bits_i;
    oe_o[1] = oe_i;
    for (int k = 0; k < n; k++) begin
      for (int l = 0; l < 4; l++) cap_o[l][79-k] = lane_i[l];
      sclk_o <= 1'b1;
      sdi_o  <= (k < 16) ? cmd_i[15-k] : 1'b0;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    cs_n_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    oe_o[0] = oe_i;
    done_o <= 1'b1;
    @(posedge clk_i);
    done_o <= 1'b0;
  endtask
endmodule // qarc_host

// ### tb/qarc_readout_tb.sv
// Purpose: Self-checking bench of the readout control.
// Assumes: 40 MHz control clock; the host model frames every transfer.
// Notes:   One note is queued per frame and compared when the host ends it.
`timescale 1ns/10ps
module qarc_readout_tb
  import qarc_pkg::*;
;
  typedef struct packed {logic chk; logic [6:0] n; logic [15:0] cmd; qarc_lanes_type l;} qarc_note_type;
  logic clk_i, srst_i, cfg_wr_i, soft_i, hard_i, fault_i, done, cs_n, sclk, serial_command_in;
  logic pdown, flush, aclr, reinit, sfail, strobe, hold, cdone, fshort, cvalid;
  qarc_cfg_type cfg_i, cfg_o;
  qarc_words_type w, prev;
  qarc_lanes_type cap;
  qarc_note_type mnt, notes[$];
  logic [7:0] crc;
  logic [3:0] lo, loe, lv;
  logic [1:0] oe_seen;
  logic [6:0] fbits, hbits;
  logic [15:0] cmd, cmd_word;
  logic [31:0] seed = 32'h2e012eea;
  int num_errors = 0, checks = 0, nstrobe = 0, xstrobe = 0;
  int nhold = 0, ndone = 0, nshort = 0, ncmd = 0, nframe = 0;
  // Released lanes show the inverse of their last bit, never a stale copy.
  assign lv = lo ^ ~loe;
  qarc_readout qarc_readout_i (.clk_i, .srst_i, .cs_n_i(cs_n), .sclk_i(sclk), .serial_command_in_i(serial_command_in),
    .result_lane_a_o(lo[0]), .result_lane_a_oe_o(loe[0]), .result_lane_b_o(lo[1]), .result_lane_b_oe_o(loe[1]),
    .result_lane_c_o(lo[2]), .result_lane_c_oe_o(loe[2]), .result_lane_d_o(lo[3]), .result_lane_d_oe_o(loe[3]),
    .cfg_wr_i, .cfg_i, .soft_reset_i(soft_i), .hard_reset_i(hard_i), .cfg_o, .conv_data_i(w),
    .crc_value_i(crc), .selftest_fault_i(fault_i), .analog_power_down_o(pdown), .sample_strobe_o(strobe),
    .sample_hold_o(hold), .conv_done_o(cdone), .analog_reinit_o(reinit), .pipe_flush_o(flush), .alert_clear_o(aclr),
    .setup_fail_o(sfail), .frame_bits_o(fbits), .frame_short_o(fshort), .cmd_word_o(cmd_word), .cmd_valid_o(cvalid));
  qarc_host qarc_host_i (.clk_i, .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(serial_command_in), .cmd_i(cmd), .lane_i(lv),
    .oe_i(loe[0]), .bits_i(fbits), .cap_o(cap), .bits_o(hbits), .oe_o(oe_seen), .done_o(done));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 32; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction
  function automatic int nbits(qarc_cfg_type c);
    int wpl;
    wpl = (c.output_lane_select == LANES_FOUR) ? 1 : (c.output_lane_select == LANES_TWO) ? 2 : 4;
    return wpl * (c.resolution_boost_enable ? 18 : 16) + (c.crc_read_enable ? 8 : 0);
  endfunction
  function automatic qarc_lanes_type exp_lanes(qarc_words_type v, qarc_cfg_type c, logic [7:0] x);
    int p[4];
    int ln;
    qarc_lanes_type l;
    l = '0;
    p = '{default: 0};
    for (int ch = 0; ch < 4; ch++) begin
      ln = (c.output_lane_select == LANES_FOUR) ? ch : (c.output_lane_select == LANES_TWO) ? ch % 2 : 0;
      for (int b = 0; b < (c.resolution_boost_enable ? 18 : 16); b++) begin
        l[ln][79-p[ln]] = v[ch][17-b];
        p[ln]++;
      end
    end
    if (c.crc_read_enable) for (int b = 0; b < 8; b++) l[0][79-p[0]-b] = x[7-b];
    return l;
  endfunction
  task automatic cmp_val(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_lanes(input qarc_lanes_type g, input qarc_lanes_type e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic rst_pulse(input logic hard);
    @(posedge clk_i);
    soft_i <= ~hard;
    hard_i <= hard;
    @(posedge clk_i);
    soft_i <= 1'b0;
    hard_i <= 1'b0;
    #1;
  endtask
  task automatic run(input qarc_cfg_type c, input logic chk);
    qarc_note_type nt;
    qarc_words_type nw;
    @(posedge clk_i);
    cfg_wr_i <= 1'b1;
    cfg_i    <= c;
    @(posedge clk_i);
    cfg_wr_i <= 1'b0;
    #1 cmp_val(16'(cfg_o), 16'(c));
    if (!c.power_down_select) repeat (8) @(posedge clk_i);
    for (int ch = 0; ch < 4; ch++) begin
      seed = lfsr(seed);
      nw[ch] = seed[17:0];
    end
    nt = '{chk, 7'(nbits(c)), seed[31:16], exp_lanes(prev, c, seed[25:18])};
    @(posedge clk_i);
    w   <= nw;
    crc <= seed[25:18];
    cmd <= seed[31:16];
    notes.push_back(nt);
    nframe++;
    qarc_host_i.frame(nbits(c));
    if (!c.power_down_select) begin
      prev = nw;
      xstrobe++;
    end
  endtask
  // ==========================================================================
  // Monitor and sequence
  // ==========================================================================
  always @(posedge clk_i) begin
    if (strobe === 1'b1) nstrobe++;
    if (hold === 1'b1) nhold++;
    if (cdone === 1'b1) ndone++;
    if (fshort === 1'b1) nshort++;
    if (cvalid === 1'b1) ncmd++;
    if (done === 1'b1 && notes.size() > 0) begin
      mnt = notes.pop_front();
      if (mnt.chk) cmp_lanes(cap, mnt.l);
      if (mnt.chk) cmp_val(16'(hbits), 16'(mnt.n));
      cmp_val(cmd_word, mnt.cmd);
      cmp_val(16'(oe_seen), 16'h0002);
    end
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    num_errors++;
    report_and_stop();
  end
  initial begin
    {srst_i, cfg_wr_i, soft_i, hard_i, fault_i} = 5'h10;
    {w, prev, crc, cmd} = '0;
    cfg_i = CFG_DEFAULT;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (90) @(posedge clk_i);
    #1 cmp_val(16'(sfail), 16'h0000);
    run(CFG_DEFAULT, 1'b0);
    for (int m = 0; m < 4; m++)
      for (int k = 0; k < 4; k++) run('{1'b0, qarc_lane_mode_type'(m), k[1], k[0]}, 1'b1);
    run('{1'b1, LANES_FOUR, 1'b1, 1'b0}, 1'b1);
    cmp_val(16'(pdown), 16'h0001);
    run('{1'b0, LANES_FOUR, 1'b1, 1'b0}, 1'b1);
    rst_pulse(1'b0);
    cmp_val(16'({flush, aclr, reinit}), 16'h0006);
    cmp_val(16'(cfg_o), 16'(cfg_i));
    run(cfg_i, 1'b0);
    fault_i <= 1'b1;
    rst_pulse(1'b1);
    cmp_val(16'({cfg_o, reinit}), 16'({CFG_DEFAULT, 1'b1}));
    repeat (90) @(posedge clk_i);
    #1 cmp_val(16'(sfail), 16'h0001);
    fault_i <= 1'b0;
    rst_pulse(1'b1);
    repeat (90) @(posedge clk_i);
    #1 cmp_val(16'(sfail), 16'h0000);
    run(CFG_DEFAULT, 1'b0);
    run(CFG_DEFAULT, 1'b1);
    repeat (10) @(posedge clk_i);
    cmp_val(16'(nstrobe), 16'(xstrobe));
    cmp_val(16'(ndone), 16'(xstrobe));
    cmp_val(16'(nhold), 16'(xstrobe * CONV_CYCLES));
    cmp_val(16'(ncmd), 16'(nframe));
    cmp_val(16'(nshort), 16'h0000);
    report_and_stop();
  end
endmodule // qarc_readout_tb
